// *** design/fanout_pkg.sv ***
// Shared constants, types and state codes for the clock fan-out control block.
//
// Operation
// [R01] Each enabled true output follows the reference clock in phase while powered up.
// [R02] Each complement output carries the inverse of the reference beside its true output.
// [R03] A feedback output carries a further copy of the reference clock.
// [R04] While power_down_n is low every clock output is released to high impedance.
// [R05] The serial port enables or disables each output pair through stored bits.
// [R06] All pair enables come out of reset set, with no serial access needed.
// [R07] Only address bytes 0xD2 (write) and 0xD3 (read) are acknowledged.
// [R08] In a write the command byte and the count byte are acknowledged and dropped.
// [R09] In a read the count byte is sent first, then the data bytes in order.
// [R10] The count byte returned in a read is nine after reset.
// [R11] Bytes run upward from the lowest, each has one acknowledge, a missing one ends it.
// [R12] Data byte seven bits 0 to 7 gate pairs 0 to 7, one enables, zero disables.
// [R13] Data byte six bits 0 to 3 gate pairs 8 to 11, bit 5 selects boosted drive.
package fanout_pkg;

    localparam int PAIRS = 12;
    localparam logic [6:0] SLAVE_ADDR = 7'h69;
    localparam logic [7:0] ADDR_WRITE = 8'hD2;
    localparam logic [7:0] ADDR_READ = 8'hD3;
    localparam logic [7:0] COUNT_RESET = 8'h09;
    localparam logic [7:0] BYTE6_RESET = 8'h8F;
    localparam logic [7:0] BYTE7_RESET = 8'hFF;
    localparam logic [4:0] WRITE_SKIP = 5'h02;
    localparam logic [4:0] READ_SKIP = 5'h01;
    localparam logic [3:0] BYTE6_INDEX = 4'h6;
    localparam logic [3:0] BYTE7_INDEX = 4'h7;
    localparam int BOOST_BIT = 5;
    localparam logic [4:0] INDEX_MAX = 5'h1F;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [11:0] ENABLE_RESET = 12'hFFF;

    // One-hot serial port states.
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_RECV = 5'b00010,
        ST_SACK = 5'b00100,
        ST_SEND = 5'b01000,
        ST_MACK = 5'b10000
    } serial_state_e;

    // Clock output pins of all pairs together.
    typedef struct packed {
        logic [11:0] true_clk;
        logic [11:0] comp_clk;
        logic [11:0] oe;
    } pair_pins_s;

endpackage

// *** design/clock_fanout_ctrl.sv ***
// Clock fan-out buffer with serial control of the pair enables that gate the clock copies.
`timescale 1ns/1ns
`default_nettype none
module clock_fanout_ctrl (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ref_clk,
    input wire logic power_down_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output fanout_pkg::pair_pins_s pair_pins,
    output logic feedback_clock_out,
    output logic feedback_oe,
    output logic drive_boost
);

    // Returns the byte sent at a given position of a read transfer.
    // Position zero is the count byte, and the data bytes follow it one by one.
    function automatic logic [7:0] read_byte(input logic [4:0] idx, input logic [7:0] b6,
                                             input logic [7:0] b7);
        logic [4:0] data_idx;
        data_idx = idx - fanout_pkg::READ_SKIP;
        if (idx == 5'h00) begin
            read_byte = fanout_pkg::COUNT_RESET; // [R10]
        end else if (data_idx == {1'b0, fanout_pkg::BYTE6_INDEX}) begin
            read_byte = b6;
        end else if (data_idx == {1'b0, fanout_pkg::BYTE7_INDEX}) begin
            read_byte = b7;
        end else begin
            read_byte = 8'h00;
        end
    endfunction

    // Synchronised serial lines and the bus events decoded from them.
    logic [2:0] scl_sync_q;
    logic [2:0] sda_sync_q;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;

    // Serial sequencer state and the byte being moved.
    fanout_pkg::serial_state_e state_q;
    logic [7:0] shift_q;
    logic [2:0] bit_cnt_q;
    logic byte_full_q;
    logic addr_phase_q;
    logic is_read_q;
    logic master_ack_q;
    logic [4:0] byte_idx_q;
    logic [4:0] data_idx;
    logic [7:0] first_byte;
    logic [7:0] next_byte;
    logic data_strobe;
    logic sda_oe_q;
    logic sda_out_q;

    // Stored control bytes in the system clock domain.
    logic [7:0] byte6_q;
    logic [7:0] byte7_q;
    logic boost_q;
    logic [11:0] enable_sys;

    // Reference clock domain copies of the controls.
    logic [11:0] en_meta_q;
    logic [11:0] en_sync_q;
    logic [11:0] en_true_q;
    logic pd_meta_q;
    logic pd_sync_q;
    logic [11:0] pair_oe_q;
    logic fb_oe_q;

    // Serial pins pass two flops, the third stage only feeds edge detection.
    // Reset leaves them high, the idle level, so no false edge follows reset.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            scl_sync_q <= 3'h7;
            sda_sync_q <= 3'h7;
        end else begin
            scl_sync_q <= {scl_sync_q[1:0], scl_in};
            sda_sync_q <= {sda_sync_q[1:0], sda_in};
        end
    end

    // Bus events seen on the synchronised lines.
    assign scl_rise = scl_sync_q[1] & ~scl_sync_q[2];
    assign scl_fall = ~scl_sync_q[1] & scl_sync_q[2];
    assign start_seen = scl_sync_q[1] & scl_sync_q[2] & ~sda_sync_q[1] & sda_sync_q[2];
    assign stop_seen = scl_sync_q[1] & scl_sync_q[2] & sda_sync_q[1] & ~sda_sync_q[2];
    assign data_idx = byte_idx_q - fanout_pkg::WRITE_SKIP;

    // Bytes offered to the master: the one after the address, the one after an acknowledge.
    assign first_byte = read_byte(byte_idx_q, byte6_q, byte7_q);
    assign next_byte = read_byte(byte_idx_q + 5'h01, byte6_q, byte7_q);

    // A data byte of a write completes at this clock fall.
    assign data_strobe = state_q == fanout_pkg::ST_RECV && scl_fall && byte_full_q &&
                         !addr_phase_q && byte_idx_q >= fanout_pkg::WRITE_SKIP;

    // Serial protocol sequencer; data moves on clock falls, samples on rises.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= fanout_pkg::ST_IDLE;
            shift_q <= 8'h00;
            bit_cnt_q <= 3'h0;
            byte_full_q <= 1'b0;
            addr_phase_q <= 1'b0;
            is_read_q <= 1'b0;
            master_ack_q <= 1'b0;
            byte_idx_q <= 5'h00;
            sda_oe_q <= 1'b0;
        end else if (start_seen) begin
            state_q <= fanout_pkg::ST_RECV;
            bit_cnt_q <= 3'h0;
            byte_full_q <= 1'b0;
            addr_phase_q <= 1'b1;
            byte_idx_q <= 5'h00;
            sda_oe_q <= 1'b0;
        end else if (stop_seen) begin
            state_q <= fanout_pkg::ST_IDLE;
            sda_oe_q <= 1'b0;
        end else begin
            case (state_q)
                fanout_pkg::ST_IDLE: begin
                    sda_oe_q <= 1'b0;
                end
                fanout_pkg::ST_RECV: begin
                    if (scl_rise) begin
                        shift_q <= {shift_q[6:0], sda_sync_q[1]};
                        bit_cnt_q <= bit_cnt_q + 3'h1;
                        byte_full_q <= (bit_cnt_q == fanout_pkg::LAST_BIT);
                    end else if (scl_fall && byte_full_q) begin
                        byte_full_q <= 1'b0;
                        if (addr_phase_q) begin
                            // Address byte: only the two block codes are answered. [R07]
                            if (shift_q == fanout_pkg::ADDR_WRITE ||
                                shift_q == fanout_pkg::ADDR_READ) begin
                                is_read_q <= shift_q[0];
                                sda_oe_q <= 1'b1;
                                state_q <= fanout_pkg::ST_SACK;
                            end else begin
                                state_q <= fanout_pkg::ST_IDLE;
                            end
                        end else begin
                            // Command and count bytes are acknowledged only. [R08]
                            sda_oe_q <= 1'b1;
                            state_q <= fanout_pkg::ST_SACK;
                            if (byte_idx_q != fanout_pkg::INDEX_MAX) begin
                                byte_idx_q <= byte_idx_q + 5'h01; // [R11]
                            end
                        end
                    end
                end
                fanout_pkg::ST_SACK: begin
                    if (scl_fall) begin
                        addr_phase_q <= 1'b0;
                        bit_cnt_q <= 3'h0;
                        if (is_read_q) begin
                            // Read opens with the count byte, index zero. [R09]
                            shift_q <= {first_byte[6:0], 1'b0};
                            sda_oe_q <= ~first_byte[7];
                            bit_cnt_q <= 3'h1;
                            state_q <= fanout_pkg::ST_SEND;
                        end else begin
                            sda_oe_q <= 1'b0;
                            state_q <= fanout_pkg::ST_RECV;
                        end
                    end
                end
                fanout_pkg::ST_SEND: begin
                    if (scl_fall) begin
                        if (bit_cnt_q == 3'h0) begin
                            sda_oe_q <= 1'b0;
                            state_q <= fanout_pkg::ST_MACK;
                        end else begin
                            sda_oe_q <= ~shift_q[7];
                            shift_q <= {shift_q[6:0], 1'b0};
                            bit_cnt_q <= bit_cnt_q + 3'h1;
                        end
                    end
                end
                fanout_pkg::ST_MACK: begin
                    if (scl_rise) begin
                        master_ack_q <= ~sda_sync_q[1];
                    end else if (scl_fall) begin
                        if (master_ack_q) begin
                            // Next byte in ascending order; no acknowledge ends it. [R11]
                            shift_q <= {next_byte[6:0], 1'b0};
                            sda_oe_q <= ~next_byte[7];
                            bit_cnt_q <= 3'h1;
                            if (byte_idx_q != fanout_pkg::INDEX_MAX) begin
                                byte_idx_q <= byte_idx_q + 5'h01;
                            end
                            state_q <= fanout_pkg::ST_SEND;
                        end else begin
                            state_q <= fanout_pkg::ST_IDLE; // [R11]
                        end
                    end
                end
                default: begin
                    state_q <= fanout_pkg::ST_IDLE;
                    sda_oe_q <= 1'b0;
                end
            endcase
        end
    end

    // Data byte six lands here; other data bytes are dropped.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            byte6_q <= fanout_pkg::BYTE6_RESET; // [R06]
        end else if (data_strobe && data_idx == {1'b0, fanout_pkg::BYTE6_INDEX}) begin
            byte6_q <= shift_q; // [R05] [R13]
        end
    end

    // Data byte seven lands here; other data bytes are dropped.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            byte7_q <= fanout_pkg::BYTE7_RESET; // [R06]
        end else if (data_strobe && data_idx == {1'b0, fanout_pkg::BYTE7_INDEX}) begin
            byte7_q <= shift_q; // [R05] [R12]
        end
    end

    // Enhanced drive select follows byte six bit five.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            boost_q <= 1'b0;
        end else begin
            boost_q <= byte6_q[fanout_pkg::BOOST_BIT]; // [R13]
        end
    end

    // Pair enables in pair order: byte seven for 0 to 7, byte six for 8 to 11.
    assign enable_sys = {byte6_q[3:0], byte7_q}; // [R12] [R13]

    // The data pin only ever pulls low; its level comes from a flop, unlike the clock outputs.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sda_out_q <= 1'b0;
        end else begin
            sda_out_q <= 1'b0;
        end
    end

    // Enables cross into the reference clock domain by two flops. Each bit gates its
    // own pair and changes only at a byte end, so bits may settle one edge apart safely.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            en_meta_q <= fanout_pkg::ENABLE_RESET;
            en_sync_q <= fanout_pkg::ENABLE_RESET; // [R06]
        end else begin
            en_meta_q <= enable_sys;
            en_sync_q <= en_meta_q;
        end
    end

    // The true outputs take a new enable while the reference is low, so no runt pulse.
    always_ff @(negedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            en_true_q <= fanout_pkg::ENABLE_RESET; // [R06]
        end else begin
            en_true_q <= en_sync_q;
        end
    end

    // The power-down pin passes two flops before the output enables use it.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pd_meta_q <= 1'b0;
            pd_sync_q <= 1'b0;
        end else begin
            pd_meta_q <= power_down_n;
            pd_sync_q <= pd_meta_q;
        end
    end

    // Output enables drop together while power-down is asserted.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pair_oe_q <= 12'h000;
            fb_oe_q <= 1'b0;
        end else begin
            pair_oe_q <= {fanout_pkg::PAIRS{pd_sync_q}}; // [R04]
            fb_oe_q <= pd_sync_q; // [R04]
        end
    end

    // Clock copies gated by the enable of their pair, held low when disabled; each
    // gate's enable only moves while its own clock copy is low.
    assign pair_pins.true_clk = {fanout_pkg::PAIRS{ref_clk}} & en_true_q; // [R01]
    assign pair_pins.comp_clk = {fanout_pkg::PAIRS{~ref_clk}} & en_sync_q; // [R02]
    assign pair_pins.oe = pair_oe_q;
    assign feedback_clock_out = ref_clk; // [R03]
    assign feedback_oe = fb_oe_q;
    assign drive_boost = boost_q;
    assign sda_out = sda_out_q;
    assign sda_oe = sda_oe_q;

endmodule
`default_nettype wire

// *** verification/serial_master_model.sv ***
// Serial bus master model that owns the clock line and pulls the data line low.
`timescale 1ns/1ns
`default_nettype none
module serial_master_model (
    input wire logic clock,
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    localparam int QUARTER = 5;
    // Both lines idle released; all changes land just after a falling clock edge.
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic wait_q();
        repeat (QUARTER) @(negedge clock);
    endtask
    // Data falls while the clock line is high, then the clock line goes low.
    task automatic start();
        sda_low = 1'b1;
        wait_q();
        scl = 1'b0;
        wait_q();
    endtask
    // Data rises while the clock line is high, leaving the bus idle.
    task automatic stop();
        sda_low = 1'b1;
        wait_q();
        scl = 1'b1;
        wait_q();
        sda_low = 1'b0;
        wait_q();
    endtask
    // One bit: data only changes with the clock line low, sampled mid high phase.
    task automatic bit_io(input logic b, output logic got);
        sda_low = !b;
        wait_q();
        scl = 1'b1;
        wait_q();
        got = sda;
        wait_q();
        scl = 1'b0;
        wait_q();
    endtask
    // Eight bits most significant first, then one acknowledge bit.
    task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                        output logic ack_out);
        for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
        bit_io(ack_in, ack_out);
    endtask
endmodule
`default_nettype wire

// *** verification/clock_fanout_ctrl_assertions.sv ***
// Concurrent checks on the ports of the clock fan-out control block.
`timescale 1ns/1ns
`default_nettype none
module clock_fanout_ctrl_assertions (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ref_clk,
    input wire logic power_down_n,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire fanout_pkg::pair_pins_s pair_pins,
    input wire logic feedback_clock_out,
    input wire logic feedback_oe,
    input wire logic drive_boost
);
    // Output clock relations, sampled just before each reference edge.
    chk_true_in_phase: assert property (@(posedge ref_clk) disable iff (!rst_n)
        pair_pins.true_clk == 12'h000) else $error("true output high while reference low");
    chk_comp_inverse: assert property (@(negedge ref_clk) disable iff (!rst_n)
        pair_pins.comp_clk == 12'h000) else $error("complement high while reference high");
    chk_feedback_copy: assert property (@(negedge ref_clk) disable iff (!rst_n)
        feedback_clock_out == 1'b1) else $error("feedback output not following reference");
    // Power-down releases and restores every output enable together.
    chk_oe_shared: assert property (@(posedge ref_clk) disable iff (!rst_n)
        pair_pins.oe == {12{feedback_oe}}) else $error("output enables disagree");
    chk_power_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !power_down_n [*4] |-> !feedback_oe) else $error("outputs driven in power-down");
    chk_power_on: assert property (@(posedge ref_clk) disable iff (!rst_n)
        power_down_n [*5] |-> feedback_oe) else $error("outputs not driven when powered");
    // Serial side: the device only moves data or settings while the clock line is low.
    chk_ack_scl_low: assert property (@(posedge clock) disable iff (!rst_n)
        $changed(sda_oe) |-> !scl_in) else $error("data drive changed with clock high");
    chk_boost_scl_low: assert property (@(posedge clock) disable iff (!rst_n)
        $changed(drive_boost) |-> !scl_in) else $error("boost changed outside a byte end");
    chk_start_release: assert property (@(posedge clock) disable iff (!rst_n)
        scl_in && $fell(sda_in) |-> !sda_oe [*6]) else $error("data driven after a start");
    // Main scenarios reached.
    cover property (@(posedge clock) disable iff (!rst_n) $rose(sda_oe));
    cover property (@(posedge clock) disable iff (!rst_n) $rose(drive_boost));
    cover property (@(posedge ref_clk) disable iff (!rst_n) $fell(feedback_oe));
endmodule
bind clock_fanout_ctrl clock_fanout_ctrl_assertions checker_i (.clock(clock), .rst_n(rst_n),
    .ref_clk(ref_clk), .power_down_n(power_down_n), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .pair_pins(pair_pins),
    .feedback_clock_out(feedback_clock_out), .feedback_oe(feedback_oe),
    .drive_boost(drive_boost));
`default_nettype wire

// *** verification/clock_fanout_ctrl_test.sv ***
// Self-checking bench for the clock fan-out control block.
`timescale 1ns/1ns
`default_nettype none
module clock_fanout_ctrl_test;
    logic clock = 1'b0;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic power_down_n = 1'b1;
    logic scl, sda_low, sda_oe, sda_out, feedback_clock_out, feedback_oe, drive_boost;
    wire sda;
    fanout_pkg::pair_pins_s pair_pins;
    int fails = 0;
    int compares = 0;
    int cycles = 0;
    logic [7:0] rx;
    logic ack;
    // Open-drain data line with a pull-up: low while either party pulls it.
    assign sda = !((sda_oe && !sda_out) || sda_low);
    always #20 clock = ~clock;
    // Reference clock of 6 ns, offset from the system clock.
    initial begin
        #1;
        forever #3 ref_clk = ~ref_clk;
    end
    clock_fanout_ctrl dut (.clock(clock), .rst_n(rst_n), .ref_clk(ref_clk),
        .power_down_n(power_down_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .pair_pins(pair_pins), .feedback_clock_out(feedback_clock_out),
        .feedback_oe(feedback_oe), .drive_boost(drive_boost));
    serial_master_model host (.clock(clock), .sda(sda), .scl(scl), .sda_low(sda_low));
    task automatic check(input logic [11:0] got, input logic [11:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("fails %0d compares %0d", fails, compares);
        if (fails == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Enabled pairs show on true or complement whatever the reference level.
    task automatic check_mask(input logic [11:0] exp);
        @(posedge ref_clk);
        #1;
        check(pair_pins.true_clk, exp);
        check(pair_pins.comp_clk, 12'h000);
        check({11'h000, feedback_clock_out}, 12'h001);
        @(negedge ref_clk);
        #1;
        check(pair_pins.comp_clk, exp);
        check(pair_pins.true_clk, 12'h000);
        check({11'h000, feedback_clock_out}, 12'h000);
        @(negedge clock);
    endtask
    // Sends one byte and compares the acknowledge (zero means taken).
    task automatic send(input logic [7:0] b, input logic exp_ack);
        host.xfer(b, 1'b1, rx, ack);
        check({11'h000, ack}, {11'h000, exp_ack});
    endtask
    // Reads one byte, answering acknowledge or not, and compares it.
    task automatic fetch(input logic [7:0] exp, input logic nack);
        host.xfer(8'hFF, nack, rx, ack);
        check({4'h0, rx}, {4'h0, exp});
    endtask
    // Full read: count byte, then data bytes 0 to 7, the last one refused.
    task automatic read_all(input logic [7:0] b6, input logic [7:0] b7);
        host.start();
        send(fanout_pkg::ADDR_READ, 1'b0);
        fetch(fanout_pkg::COUNT_RESET, 1'b0);
        for (int i = 0; i < 8; i++) begin
            fetch(i == 6 ? b6 : (i == 7 ? b7 : 8'h00), i == 7);
        end
        host.stop();
    endtask
    // Cuts a hang short well beyond the expected run length.
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            $display("mismatch at %0t: run did not finish in time", $time);
            complete_run();
        end
    end
    initial begin
        repeat (3) @(negedge clock);
        rst_n = 1'b1;
        repeat (6) @(negedge clock);
        check_mask(fanout_pkg::ENABLE_RESET);
        check(pair_pins.oe, 12'hFFF);
        check({11'h000, drive_boost}, 12'h000);
        read_all(fanout_pkg::BYTE6_RESET, fanout_pkg::BYTE7_RESET);
        host.start();
        send(8'hD4, 1'b1);
        host.stop();
        host.start();
        send(fanout_pkg::ADDR_WRITE, 1'b0);
        send(8'hAA, 1'b0);
        send(8'h55, 1'b0);
        for (int i = 0; i < 8; i++) send(i == 6 ? 8'h21 : (i == 7 ? 8'h5A : 8'h00), 1'b0);
        host.stop();
        check_mask(12'h15A);
        check({11'h000, drive_boost}, 12'h001);
        read_all(8'h21, 8'h5A);
        power_down_n = 1'b0;
        repeat (2) @(negedge clock);
        check(pair_pins.oe, 12'h000);
        check({11'h000, feedback_oe}, 12'h000);
        power_down_n = 1'b1;
        repeat (2) @(negedge clock);
        check(pair_pins.oe, 12'hFFF);
        check({11'h000, feedback_oe}, 12'h001);
        complete_run();
    end
endmodule
`default_nettype wire
